// ===== dv/psc_regs_tb.sv
// Self-checking testbench of the power sign and configuration bank.
`timescale 1ns/100ps
`default_nettype none
module psc_regs_tb;
  import psc_pkg::*;
  // Stimulus and observed signals.
  logic clk_sys;
  logic rst;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic pwr_valid;
  psc_phase_pwr_t pwr_a;
  psc_phase_pwr_t pwr_b;
  psc_phase_pwr_t pwr_c;
  logic sample_valid;
  psc_chan_t volt_in;
  psc_chan_t curr_in;
  logic [2:0] zero_cross;
  psc_chan_t volt_out;
  psc_chan_t curr_out;
  logic hpf_enable;
  logic lpf_settling;
  logic shared_pin;
  logic irq;
  int num_errors;
  int comparisons;

  ////////////////////////////////////////////////////////////////////////////
  // Device under test.
  psc_regs i_psc_regs (
    .CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PWR_VALID(pwr_valid), .PWR_A(pwr_a),
    .PWR_B(pwr_b), .PWR_C(pwr_c), .SAMPLE_VALID(sample_valid),
    .VOLT_IN(volt_in), .CURR_IN(curr_in), .ZERO_CROSS(zero_cross),
    .VOLT_OUT(volt_out), .CURR_OUT(curr_out), .HPF_ENABLE(hpf_enable),
    .LPF_SETTLING(lpf_settling), .SHARED_PIN(shared_pin), .IRQ(irq)
  );

  // The 20 MHz system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  task automatic chk(input string name, input logic [95:0] exp,
                     input logic [95:0] got);
    comparisons++;
    // Case inequality, so an unknown never passes.
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One write cycle; the strobe drops at the following edge.
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // One read cycle; data stand only in the cycle after the strobe.
  task automatic rd_chk(input string name, input logic [15:0] a,
                        input logic [15:0] exp);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask

  function automatic psc_phase_pwr_t ph(input int ac, input int fa,
                                        input int re, input int fr,
                                        input int ap);
    psc_phase_pwr_t p;
    p.act = 24'(ac);
    p.fact = 24'(fa);
    p.react = 24'(re);
    p.freact = 24'(fr);
    p.app = 24'(ap);
    return p;
  endfunction

  // Present one set of power results for a single cycle.
  task automatic pwr(input psc_phase_pwr_t a, input psc_phase_pwr_t b,
                     input psc_phase_pwr_t c);
    @(posedge clk_sys);
    pwr_valid <= 1'b1;
    pwr_a <= a;
    pwr_b <= b;
    pwr_c <= c;
    @(posedge clk_sys);
    pwr_valid <= 1'b0;
  endtask

  // Present one channel sample; outputs settle one edge later.
  task automatic sample(input psc_chan_t v, input psc_chan_t c);
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    volt_in <= v;
    curr_in <= c;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    #1;
  endtask

  task automatic test_done;
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset_values;
    rd_chk("sign_rst", PSC_ADDR_SIGN, 16'h0000);
    rd_chk("cfg_rst", PSC_ADDR_CONFIG, 16'h0010);
    chk("hpf_rst", 1'b1, hpf_enable);
    rd_chk("mode_rst", PSC_ADDR_MEASUREMENT_MODE_REGISTER, 16'h0000);
    rd_chk("comp_rst", PSC_ADDR_COMPUTATION_MODE_REGISTER, 16'h01ff);
    rd_chk("cf_rst", PSC_ADDR_PULSE_OUTPUT_MODE_REGISTER, 16'h0088);
    // An unmapped place answers zero.
    rd_chk("unmapped", 16'h0000, 16'h0000);
  endtask

  // Totals first, then fundamentals with custom path selections.
  task automatic t_signs;
    pwr(ph(-5, 1, 1, 1, 1), ph(1, 1, -3, 1, 1), ph(1, 1, 1, 1, 1));
    rd_chk("sign_tot", PSC_ADDR_SIGN, 16'h00a9);
    wr_reg(PSC_ADDR_MEASUREMENT_MODE_REGISTER, 16'h0003);
    // Path one: C fundamental active; two: A fundamental reactive.
    wr_reg(PSC_ADDR_COMPUTATION_MODE_REGISTER, 16'h01cc);
    // Path three gets a reserved type, so its sign stays positive.
    wr_reg(PSC_ADDR_PULSE_OUTPUT_MODE_REGISTER, 16'h0163);
    pwr(ph(1, 1, 1, -2, -9), ph(1, 1, 1, 1, -9), ph(1, -4, 1, 1, -9));
    rd_chk("sign_fund", PSC_ADDR_SIGN, 16'h009c);
    // Host writes must not disturb the flags.
    wr_reg(PSC_ADDR_SIGN, 16'hffff);
    rd_chk("sign_ro", PSC_ADDR_SIGN, 16'h009c);
    // Apparent sum of path three alone, all phases negative.
    wr_reg(PSC_ADDR_PULSE_OUTPUT_MODE_REGISTER, 16'h0080);
    pwr(ph(1, 1, 1, 1, -9), ph(1, 1, 1, 1, -9), ph(1, 1, 1, 1, -9));
    rd_chk("sign_app", PSC_ADDR_SIGN, 16'h0100);
    // Empty paths two and three ignore a negative apparent sum.
    wr_reg(PSC_ADDR_COMPUTATION_MODE_REGISTER, 16'h0007);
    wr_reg(PSC_ADDR_PULSE_OUTPUT_MODE_REGISTER, 16'h0090);
    pwr(ph(1, 1, 1, 1, -9), ph(1, 1, 1, 1, -9), ph(1, 1, 1, 1, -9));
    rd_chk("sign_empty", PSC_ADDR_SIGN, 16'h0000);
  endtask

  // Sticky status of rising flags, masked level interrupt, clear.
  task automatic t_irq;
    rd_chk("status", PSC_ADDR_IRQ_STATUS, 16'h01bd);
    chk("irq_masked", 1'b0, irq);
    wr_reg(PSC_ADDR_IRQ_ENABLE, 16'h0100);
    rd_chk("enable", PSC_ADDR_IRQ_ENABLE, 16'h0100);
    chk("irq_on", 1'b1, irq);
    wr_reg(PSC_ADDR_IRQ_CLEAR, 16'h01ff);
    rd_chk("status_clr", PSC_ADDR_IRQ_STATUS, 16'h0000);
    chk("irq_off", 1'b0, irq);
  endtask

  task automatic t_config;
    psc_chan_t v;
    psc_chan_t c;
    v = 96'h444444_333333_222222_111111;
    c = 96'h888888_777777_666666_555555;
    wr_reg(PSC_ADDR_CONFIG, 16'hffff);
    rd_chk("cfg_mask", PSC_ADDR_CONFIG, 16'h003b);
    chk("hpf_on", 1'b1, hpf_enable);
    chk("lpf_settle", 1'b1, lpf_settling);
    sample(v, c);
    chk("volt_swap", c, volt_out);
    chk("curr_swap", v, curr_out);
    wr_reg(PSC_ADDR_CONFIG, 16'h0000);
    rd_chk("cfg_zero", PSC_ADDR_CONFIG, 16'h0000);
    chk("hpf_off", 1'b0, hpf_enable);
    sample(v, c);
    chk("volt_pass", v, volt_out);
    chk("curr_pass", c, curr_out);
  endtask

  // Every pin-function code: the chosen source only reaches the pin.
  task automatic t_pin;
    logic [2:0] sel;
    for (int k = 0; k < 4; k++)
    begin
      sel = (k == 0) ? 3'h0 : 3'(1 << (k - 1));
      wr_reg(PSC_ADDR_CONFIG, 16'(k));
      @(posedge clk_sys);
      zero_cross <= 3'h7 ^ sel;
      sample_valid <= (k != 0);
      @(posedge clk_sys);
      zero_cross <= sel;
      sample_valid <= (k == 0);
      #1;
      chk("pin_off", 1'b0, shared_pin);
      @(posedge clk_sys);
      zero_cross <= 3'h0;
      sample_valid <= 1'b0;
      #1;
      chk("pin_on", 1'b1, shared_pin);
    end
  endtask

  // A reset in mid-run returns flags to positive.
  task automatic t_midreset;
    pwr(ph(-1, -1, -1, -1, 1), ph(1, 1, 1, 1, 1), ph(1, 1, 1, 1, 1));
    rd_chk("sign_pre", PSC_ADDR_SIGN, 16'h0011);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk("sign_rst2", PSC_ADDR_SIGN, 16'h0000);
    rd_chk("cfg_rst2", PSC_ADDR_CONFIG, 16'h0010);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    num_errors = 0;
    comparisons = 0;
    rst = 1'b1;
    addr = 16'h0000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    pwr_valid = 1'b0;
    pwr_a = '0;
    pwr_b = '0;
    pwr_c = '0;
    sample_valid = 1'b0;
    volt_in = '0;
    curr_in = '0;
    zero_cross = 3'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_values();
    t_signs();
    t_irq();
    t_config();
    t_pin();
    t_midreset();
    test_done();
  end

  // Watchdog: the run needs a few hundred cycles at most.
  initial
  begin
    #(50 * 20000);
    num_errors++;
    test_done();
  end
endmodule // psc_regs_tb
`default_nettype wire

// ===== src/psc_pkg.sv
// Package: register map, fields and timing of the sign and config bank.
package psc_pkg;

  // Register offsets as word addresses on the plain host port.
  localparam logic [15:0] PSC_ADDR_SIGN = 16'he617;
  localparam logic [15:0] PSC_ADDR_CONFIG = 16'he618;
  localparam logic [15:0] PSC_ADDR_MEASUREMENT_MODE_REGISTER = 16'he700;
  localparam logic [15:0] PSC_ADDR_COMPUTATION_MODE_REGISTER = 16'he701;
  localparam logic [15:0] PSC_ADDR_PULSE_OUTPUT_MODE_REGISTER = 16'he702;
  localparam logic [15:0] PSC_ADDR_IRQ_STATUS = 16'he710;
  localparam logic [15:0] PSC_ADDR_IRQ_CLEAR = 16'he711;
  localparam logic [15:0] PSC_ADDR_IRQ_ENABLE = 16'he712;

  // Sign register field positions.
  localparam int PSC_SIGN_ACT_LSB = 0;
  localparam int PSC_SIGN_SUM1 = 3;
  localparam int PSC_SIGN_REACT_LSB = 4;
  localparam int PSC_SIGN_SUM2 = 7;
  localparam int PSC_SIGN_SUM3 = 8;
  localparam logic [15:0] PSC_SIGN_MASK = 16'h01ff;

  // Configuration register field positions and reset value.
  localparam int PSC_CFG_PIN_LSB = 0;
  localparam int PSC_CFG_SWAP = 3;
  localparam int PSC_CFG_HPF = 4;
  localparam int PSC_CFG_LPF = 5;
  localparam logic [15:0] PSC_CFG_MASK = 16'h003b;
  localparam logic [15:0] PSC_CFG_RESET = 16'h0010;

  // Measurement mode source selects.
  localparam int PSC_MM_ACT_SEL = 0;
  localparam int PSC_MM_REACT_SEL = 1;
  localparam logic [15:0] PSC_MM_MASK = 16'h0003;

  // Pulse-path selection defaults: all phases, active/reactive/apparent.
  localparam logic [15:0] PSC_COMP_RESET = 16'h01ff;
  localparam logic [15:0] PSC_CF_RESET = 16'h0088;
  localparam logic [15:0] PSC_COMP_MASK = 16'h01ff;
  localparam logic [15:0] PSC_CF_MASK = 16'h01ff;

  // Power types carried by a pulse path.
  localparam logic [2:0] PSC_PT_ACT = 3'h0;
  localparam logic [2:0] PSC_PT_REACT = 3'h1;
  localparam logic [2:0] PSC_PT_APP = 3'h2;
  localparam logic [2:0] PSC_PT_FACT = 3'h3;
  localparam logic [2:0] PSC_PT_FREACT = 3'h4;

  // Low-pass settling times and their cycle counts at 20 MHz.
  localparam longint PSC_CLK_HZ = 20000000;
  localparam longint PSC_SETTLE_SHORT_MS = 650;
  localparam longint PSC_SETTLE_LONG_MS = 1300;
  localparam longint PSC_SETTLE_SHORT_CYC =
    PSC_SETTLE_SHORT_MS * PSC_CLK_HZ / 1000;
  localparam longint PSC_SETTLE_LONG_CYC =
    PSC_SETTLE_LONG_MS * PSC_CLK_HZ / 1000;
  localparam int PSC_SETTLE_W = 26;

  // Pin-function codes of the shared pin.
  typedef enum logic [1:0] {
    PSC_PIN_READY = 2'h0,
    PSC_PIN_ZX_A = 2'h1,
    PSC_PIN_ZX_B = 2'h2,
    PSC_PIN_ZX_C = 2'h3
  } psc_pin_t;

  // One phase worth of signed power results.
  typedef struct packed {
    logic signed [23:0] act;
    logic signed [23:0] fact;
    logic signed [23:0] react;
    logic signed [23:0] freact;
    logic signed [23:0] app;
  } psc_phase_pwr_t;

  // Four channel samples (A, B, C, neutral).
  typedef struct packed {
    logic signed [23:0] ch_n;
    logic signed [23:0] ch_c;
    logic signed [23:0] ch_b;
    logic signed [23:0] ch_a;
  } psc_chan_t;

endpackage

// ===== src/psc_regs.sv
// Module: power sign flags and datapath configuration register bank.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Bits 0-2: phase active power negative flags
// - Bits 4-6: phase reactive power negative flags
// - Bit 3: pulse path one sum negative
// - Bit 7: pulse path two sum negative
// - Bit 8: pulse path three sum negative
// - Bits 15:9 read zero; flags reset positive
// - Bits 1:0 choose shared pin function
// - Config bit 2 reserved, reads zero
// - Bit 3 swaps voltage and current channels
// - Bit 4 enables high-pass filters, resets one
// - Bit 5 selects low-pass settling, resets zero
// - Settling 650 ms or 1300 ms
module psc_regs
  import psc_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST,
  // Host register port.
  input wire logic [15:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Power results from the datapath.
  input wire logic PWR_VALID,
  input wire psc_pkg::psc_phase_pwr_t PWR_A,
  input wire psc_pkg::psc_phase_pwr_t PWR_B,
  input wire psc_pkg::psc_phase_pwr_t PWR_C,
  // Channel samples and sample-ready event.
  input wire logic SAMPLE_VALID,
  input wire psc_pkg::psc_chan_t VOLT_IN,
  input wire psc_pkg::psc_chan_t CURR_IN,
  input wire logic [2:0] ZERO_CROSS,
  // Swapped channels and filter controls.
  output psc_pkg::psc_chan_t VOLT_OUT,
  output psc_pkg::psc_chan_t CURR_OUT,
  output logic HPF_ENABLE,
  output logic LPF_SETTLING,
  // Shared pin, interrupt.
  output logic SHARED_PIN,
  output logic IRQ
);
  import psc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Stored sign flags, bits 8:0.
  logic [8:0] sign_r;
  // Configuration register, bits that exist.
  logic [15:0] cfg_r;
  // Source selects and path selects.
  logic [15:0] measurement_mode_register_r;
  logic [15:0] comp_r;
  logic [15:0] pulse_output_mode_register_r;
  // Interrupt status and enable.
  logic [8:0] irq_stat_r;
  logic [8:0] irq_en_r;
  // Settling counter behind the LPF_SETTLING flag.
  logic [PSC_SETTLE_W-1:0] settle_r;
  // Next sign value from the datapath.
  logic [8:0] sign_nxt;

  // Signed sum of one pulse path, chosen by phase mask and power type.
  function automatic logic path_neg(input logic [2:0] sel,
                                    input logic [2:0] ptype,
                                    input psc_phase_pwr_t a,
                                    input psc_phase_pwr_t b,
                                    input psc_phase_pwr_t c);
    logic signed [25:0] sum;
    logic signed [23:0] v [3];
    psc_phase_pwr_t p [3];
    sum = '0;
    p[0] = a;
    p[1] = b;
    p[2] = c;
    for (int i = 0; i < 3; i++)
    begin
      unique case (ptype)
        PSC_PT_ACT: v[i] = p[i].act;
        PSC_PT_REACT: v[i] = p[i].react;
        PSC_PT_APP: v[i] = p[i].app;
        PSC_PT_FACT: v[i] = p[i].fact;
        PSC_PT_FREACT: v[i] = p[i].freact;
        default: v[i] = '0;
      endcase
      if (sel[i])
      begin
        sum = sum + 26'(v[i]);
      end
    end
    // Reserved power types add zero to the sum, so the sign reads positive.
    return sum[25];
  endfunction

  // Combine the datapath results into the sign flags.
  always_comb
  begin
    sign_nxt[PSC_SIGN_ACT_LSB] = measurement_mode_register_r[PSC_MM_ACT_SEL]
      ? PWR_A.fact[23] : PWR_A.act[23];
    sign_nxt[PSC_SIGN_ACT_LSB+1] = measurement_mode_register_r[PSC_MM_ACT_SEL]
      ? PWR_B.fact[23] : PWR_B.act[23];
    sign_nxt[PSC_SIGN_ACT_LSB+2] = measurement_mode_register_r[PSC_MM_ACT_SEL]
      ? PWR_C.fact[23] : PWR_C.act[23];
    sign_nxt[PSC_SIGN_REACT_LSB] = measurement_mode_register_r[PSC_MM_REACT_SEL]
      ? PWR_A.freact[23] : PWR_A.react[23];
    sign_nxt[PSC_SIGN_REACT_LSB+1] = measurement_mode_register_r[PSC_MM_REACT_SEL]
      ? PWR_B.freact[23] : PWR_B.react[23];
    sign_nxt[PSC_SIGN_REACT_LSB+2] = measurement_mode_register_r[PSC_MM_REACT_SEL]
      ? PWR_C.freact[23] : PWR_C.react[23];
    sign_nxt[PSC_SIGN_SUM1] = path_neg(comp_r[2:0], pulse_output_mode_register_r[2:0],
                                       PWR_A, PWR_B, PWR_C);
    sign_nxt[PSC_SIGN_SUM2] = path_neg(comp_r[5:3], pulse_output_mode_register_r[5:3],
                                       PWR_A, PWR_B, PWR_C);
    sign_nxt[PSC_SIGN_SUM3] = path_neg(comp_r[8:6], pulse_output_mode_register_r[8:6],
                                       PWR_A, PWR_B, PWR_C);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sign flags: only the datapath writes them; host writes never reach here.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      sign_r <= '0;
    end
    else if (PWR_VALID)
    begin
      sign_r <= sign_nxt;
    end
  end

  // Writable configuration; reserved bits are masked off on the way in.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      cfg_r <= PSC_CFG_RESET;
      measurement_mode_register_r <= '0;
      comp_r <= PSC_COMP_RESET;
      pulse_output_mode_register_r <= PSC_CF_RESET;
      irq_en_r <= '0;
    end
    else if (WR)
    begin
      unique case (ADDR)
        PSC_ADDR_CONFIG: cfg_r <= WDATA & PSC_CFG_MASK;
        PSC_ADDR_MEASUREMENT_MODE_REGISTER: measurement_mode_register_r <= WDATA & PSC_MM_MASK;
        PSC_ADDR_COMPUTATION_MODE_REGISTER: comp_r <= WDATA & PSC_COMP_MASK;
        PSC_ADDR_PULSE_OUTPUT_MODE_REGISTER: pulse_output_mode_register_r <= WDATA & PSC_CF_MASK;
        PSC_ADDR_IRQ_ENABLE: irq_en_r <= WDATA[8:0];
        default: ;
      endcase
    end
  end

  // Sticky status: a flag that turns negative sets its bit; set beats clear.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      irq_stat_r <= '0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~((WR && ADDR == PSC_ADDR_IRQ_CLEAR)
                                    ? WDATA[8:0] : 9'h000))
                    | (PWR_VALID ? (sign_nxt & ~sign_r) : 9'h000);
    end
  end

  // Read port: data one cycle after the strobe, zero for unmapped words.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      RDATA <= '0;
    end
    else if (RD)
    begin
      unique case (ADDR)
        PSC_ADDR_SIGN: RDATA <= {7'h00, sign_r} & PSC_SIGN_MASK;
        PSC_ADDR_CONFIG: RDATA <= cfg_r;
        PSC_ADDR_MEASUREMENT_MODE_REGISTER: RDATA <= measurement_mode_register_r;
        PSC_ADDR_COMPUTATION_MODE_REGISTER: RDATA <= comp_r;
        PSC_ADDR_PULSE_OUTPUT_MODE_REGISTER: RDATA <= pulse_output_mode_register_r;
        PSC_ADDR_IRQ_STATUS: RDATA <= {7'h00, irq_stat_r};
        PSC_ADDR_IRQ_ENABLE: RDATA <= {7'h00, irq_en_r};
        default: RDATA <= '0;
      endcase
    end
    else
    begin
      RDATA <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel swap, registered per sample so outputs come from flops.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      VOLT_OUT <= '0;
      CURR_OUT <= '0;
    end
    else if (SAMPLE_VALID)
    begin
      VOLT_OUT <= cfg_r[PSC_CFG_SWAP] ? CURR_IN : VOLT_IN;
      CURR_OUT <= cfg_r[PSC_CFG_SWAP] ? VOLT_IN : CURR_IN;
    end
  end

  // Shared pin: sample-ready pulse or a phase zero-crossing level.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      SHARED_PIN <= 1'b0;
    end
    else
    begin
      unique case (psc_pin_t'(cfg_r[PSC_CFG_PIN_LSB +: 2]))
        PSC_PIN_READY: SHARED_PIN <= SAMPLE_VALID;
        PSC_PIN_ZX_A: SHARED_PIN <= ZERO_CROSS[0];
        PSC_PIN_ZX_B: SHARED_PIN <= ZERO_CROSS[1];
        PSC_PIN_ZX_C: SHARED_PIN <= ZERO_CROSS[2];
      endcase
    end
  end

  // Filter controls, and a settling flag held high while the filter settles.
  // The count restarts on any config write, since that may change the filter.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      HPF_ENABLE <= 1'b1;
      LPF_SETTLING <= 1'b1;
      settle_r <= PSC_SETTLE_W'(PSC_SETTLE_SHORT_CYC - 1);
    end
    else
    begin
      HPF_ENABLE <= cfg_r[PSC_CFG_HPF];
      if (WR && ADDR == PSC_ADDR_CONFIG)
      begin
        settle_r <= WDATA[PSC_CFG_LPF]
                    ? PSC_SETTLE_W'(PSC_SETTLE_LONG_CYC - 1)
                    : PSC_SETTLE_W'(PSC_SETTLE_SHORT_CYC - 1);
        LPF_SETTLING <= 1'b1;
      end
      else if (settle_r != '0)
      begin
        settle_r <= settle_r - 1'b1;
      end
      else
      begin
        LPF_SETTLING <= 1'b0;
      end
    end
  end

  // Level interrupt, high while an enabled status bit is set.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= |(irq_stat_r & irq_en_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb_sys @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_sign_read;
    RD && ADDR == PSC_ADDR_SIGN;
  endsequence
  AST_SIGN_UPPER_ZERO: assert property (s_sign_read
    |=> RDATA[15:9] == 7'h00)
    else $error("Sign register upper bits not zero.");
  AST_SIGN_READ_MATCH: assert property (s_sign_read
    |=> RDATA[8:0] == $past(sign_r))
    else $error("Sign read data does not match flags.");
  AST_ACT_A_SIGN: assert property (PWR_VALID
    && !measurement_mode_register_r[PSC_MM_ACT_SEL] |=> sign_r[0] == $past(PWR_A.act[23]))
    else $error("Phase A active sign wrong.");
  AST_REACT_C_SIGN: assert property (PWR_VALID
    && measurement_mode_register_r[PSC_MM_REACT_SEL] |=> sign_r[6] == $past(PWR_C.freact[23]))
    else $error("Phase C reactive sign wrong.");
  AST_SUM1_ALLACT: assert property (PWR_VALID && comp_r[2:0] == 3'h7
    && pulse_output_mode_register_r[2:0] == PSC_PT_ACT && PWR_A.act >= 0 && PWR_B.act >= 0
    && PWR_C.act >= 0 |=> !sign_r[3])
    else $error("Path one sum sign wrong.");
  AST_SUM2_NONE: assert property (PWR_VALID && comp_r[5:3] == 3'h0
    |=> !sign_r[7])
    else $error("Path two empty sum negative.");
  AST_SUM3_NONE: assert property (PWR_VALID && comp_r[8:6] == 3'h0
    |=> !sign_r[8])
    else $error("Path three empty sum negative.");
  AST_SIGN_HOLD: assert property (!PWR_VALID |=> $stable(sign_r))
    else $error("Sign flags changed without a result.");
  AST_CFG_BIT2_ZERO: assert property (RD && ADDR == PSC_ADDR_CONFIG
    |=> !RDATA[2])
    else $error("Reserved config bit reads one.");
  AST_SWAP: assert property (SAMPLE_VALID && cfg_r[PSC_CFG_SWAP]
    |=> VOLT_OUT == $past(CURR_IN) && CURR_OUT == $past(VOLT_IN))
    else $error("Channel swap not applied.");
  AST_PIN_ZXB: assert property (cfg_r[1:0] == 2'h2
    |=> SHARED_PIN == $past(ZERO_CROSS[1]))
    else $error("Shared pin not following phase B.");
  AST_HPF: assert property (WR && ADDR == PSC_ADDR_CONFIG ##1 1'b1
    |=> HPF_ENABLE == $past(WDATA[PSC_CFG_HPF], 2))
    else $error("High-pass enable not following config.");
  AST_SETTLE_LOAD: assert property (WR && ADDR == PSC_ADDR_CONFIG
    && WDATA[PSC_CFG_LPF] |=> LPF_SETTLING
    && settle_r == PSC_SETTLE_W'(PSC_SETTLE_LONG_CYC - 1))
    else $error("Long settling not loaded.");
  AST_SETTLE_SHORT: assert property (WR && ADDR == PSC_ADDR_CONFIG
    && !WDATA[PSC_CFG_LPF] |=> LPF_SETTLING
    && settle_r == PSC_SETTLE_W'(PSC_SETTLE_SHORT_CYC - 1))
    else $error("Short settling not loaded.");

endmodule // psc_regs

`default_nettype wire
